/* File: hdl/cmk_params.svh */
// Timing counts and reset values for the cable marker connection controller
`ifndef CMK_PARAMS_SVH
`define CMK_PARAMS_SVH

// Supply stability limit, in microseconds, and clock rate in MHz
`define CMK_STABLE_LIMIT_US 2000
`define CMK_CLK_MHZ 100
// Cycles allowed from supply appearance to the assigned state
`define CMK_STABLE_LIMIT_CYC (`CMK_STABLE_LIMIT_US * `CMK_CLK_MHZ)
// Width of the stability counter
`define CMK_CNT_W 24
// Reset value of the termination enable (present)
`define CMK_TERM_RESET 1'b1

`endif

/* File: hdl/cmk_pkg.sv */
// Types for the cable marker connection controller
package cmk_pkg;

   // Connection state, Gray coded along power-on to assigned path
   typedef enum logic [0:0] {
      CMK_POWER_ON = 1'b0,
      CMK_ADDR_ASSIGNED = 1'b1
   } cmk_state_e;

   // Address the marker answers
   typedef enum logic [0:0] {
      CMK_ADDR_PRIME = 1'b0,
      CMK_ADDR_DPRIME = 1'b1
   } cmk_addr_e;

endpackage

/* File: hdl/cmk_marker_fsm.sv */
// Connection state machine of a cable marker chip
`timescale 1ns/1ns
`include "cmk_params.svh"

module cmk_marker_fsm
   import cmk_pkg::*;
#(
   parameter int unsigned STABLE_LIMIT_CYC = `CMK_STABLE_LIMIT_CYC,
   parameter bit MULTI_MARKER = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic supplyOk,
   input wire logic bootDone,
   input wire logic addrStrap,
   input wire logic hardResetSeen,
   input wire logic cableResetSeen,
   input wire logic msgValid,
   input wire logic msgForPrime,
   input wire logic msgForDPrime,
   output logic msgAccept,
   output logic termPresent,
   output logic supplyDraw,
   output logic addrAssigned,
   output logic answersDPrime,
   output logic stableFault
);

   // ==========================================================
   // State record
   // ==========================================================
   typedef struct packed {
      logic [2:0] supSync;          // Supply level synchroniser
      logic supLvl;                 // Last level stages 2 and 3 agreed on
      cmk_state_e state;            // Connection state
      logic strapTaken;             // Strap caught after reset release
      cmk_addr_e addr;              // Fixed answer address
      logic [`CMK_CNT_W-1:0] cnt;   // Cycles since supply appeared
      logic fault;                  // Stability limit overrun, sticky
      logic term;                   // Ra termination enable
   } cmk_st_s;

   cmk_st_s st_reg;
   cmk_st_s st_next;
   logic supStable;   // Supply level after agreement of stages 2 and 3
   logic forceReset;  // Any event that restarts the marker
   logic addrHit;     // Message matches this marker's address

   // Accepted supply level: it moves only when stages two and three
   // agree, so a one-cycle dip on the supply pin is not taken as a
   // loss; the price is one more cycle before a real loss is seen
   assign supStable = (st_reg.supSync[1] == st_reg.supSync[2]) ?
      st_reg.supSync[2] : st_reg.supLvl;
   assign forceReset = ~supStable | hardResetSeen | cableResetSeen;

   // Address match; a lone marker never claims the second address
   always_comb begin
      if (st_reg.addr == CMK_ADDR_DPRIME) begin
         addrHit = msgForDPrime;
      end else begin
         addrHit = msgForPrime;
      end
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_next = st_reg;
      st_next.supSync = {st_reg.supSync[1:0], supplyOk};
      // Remember the agreed level for cycles in which the stages differ
      st_next.supLvl = supStable;
      // Strap caught once, after reset; never again while powered
      if (!st_reg.strapTaken) begin
         st_next.strapTaken = 1'b1;
         if (MULTI_MARKER && addrStrap) begin
            st_next.addr = CMK_ADDR_DPRIME;
         end else begin
            st_next.addr = CMK_ADDR_PRIME;
         end
      end
      unique case (st_reg.state)
         CMK_POWER_ON: begin
            // Ra stays while booting or while supply is absent
            st_next.term = 1'b1;
            if (!supStable) begin
               st_next.cnt = '0;
            end else begin
               if (st_reg.cnt != '1) begin
                  st_next.cnt = st_reg.cnt + 1'b1;
               end
               // Overrun is flagged but boot may still finish late
               if (st_reg.cnt >= (`CMK_CNT_W)'(STABLE_LIMIT_CYC)) begin
                  st_next.fault = 1'b1;
               end
               if (bootDone && !hardResetSeen && !cableResetSeen) begin
                  st_next.state = CMK_ADDR_ASSIGNED;
                  st_next.term = 1'b0;
               end
            end
         end
         CMK_ADDR_ASSIGNED: begin
            st_next.term = 1'b0;
            if (forceReset) begin
               st_next.state = CMK_POWER_ON;
               st_next.cnt = '0;
               st_next.term = 1'b1;
            end
         end
      endcase
   end

   // ==========================================================
   // Registers; power-on reset also returns to power-on
   // ==========================================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg.supSync <= 3'h0;
         st_reg.supLvl <= 1'b0;
         st_reg.state <= CMK_POWER_ON;
         st_reg.strapTaken <= 1'b0;
         st_reg.addr <= CMK_ADDR_PRIME;
         st_reg.cnt <= '0;
         st_reg.fault <= 1'b0;
         st_reg.term <= `CMK_TERM_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Messages are taken only when assigned and addressed to us
   assign msgAccept = msgValid & addrHit & ~forceReset &
      (st_reg.state == CMK_ADDR_ASSIGNED);
   assign termPresent = st_reg.term;
   // Every marker draws supply while the supply is stable, the second-address one included
   assign supplyDraw = supStable &
      (MULTI_MARKER || st_reg.addr == CMK_ADDR_PRIME);
   assign addrAssigned = (st_reg.state == CMK_ADDR_ASSIGNED);
   assign answersDPrime = (st_reg.addr == CMK_ADDR_DPRIME);
   assign stableFault = st_reg.fault;

   // ==========================================================
   // Checks
   // ==========================================================
   sequence s_enter_assigned;
      st_reg.state == CMK_POWER_ON ##1 st_reg.state == CMK_ADDR_ASSIGNED;
   endsequence

   // All checks sleep during power-on reset
   a_no_answer_poweron: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.state == CMK_POWER_ON |-> !msgAccept)
      else $error("message accepted in power-on state");
   a_term_in_poweron: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.state == CMK_POWER_ON |-> termPresent)
      else $error("termination missing in power-on state");
   a_term_removed: assert property (
      @(posedge clk) disable iff (rst)
      s_enter_assigned |-> !termPresent)
      else $error("termination kept in assigned state");
   a_boot_advance: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.state == CMK_POWER_ON && supStable && bootDone &&
      !hardResetSeen && !cableResetSeen |=> addrAssigned)
      else $error("boot done did not assign address");
   a_reset_return: assert property (
      @(posedge clk) disable iff (rst)
      addrAssigned && (hardResetSeen || cableResetSeen)
      |=> !addrAssigned)
      else $error("reset did not return to power-on");
   a_supply_loss: assert property (
      @(posedge clk) disable iff (rst)
      addrAssigned && !supStable |=> !addrAssigned)
      else $error("supply loss did not return to power-on");
   a_addr_fixed: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.strapTaken |=> $stable(answersDPrime))
      else $error("address changed after reset");
   a_lone_prime: assert property (
      @(posedge clk) disable iff (rst)
      !MULTI_MARKER |-> !answersDPrime)
      else $error("lone marker claims second address");
   a_answer_hit: assert property (
      @(posedge clk) disable iff (rst)
      addrAssigned && supStable && msgValid && addrHit &&
      !hardResetSeen && !cableResetSeen |-> msgAccept)
      else $error("addressed message not accepted");
   a_fault_limit: assert property (
      @(posedge clk) disable iff (rst)
      st_reg.state == CMK_POWER_ON && supStable &&
      st_reg.cnt >= (`CMK_CNT_W)'(STABLE_LIMIT_CYC)
      |=> stableFault)
      else $error("stability overrun not flagged");
   // Fault stays set until the next power-on reset
   a_fault_sticky: assert property (
      @(posedge clk) disable iff (rst)
      stableFault |=> stableFault)
      else $error("stability fault cleared without reset");
   // No boot strobe, no move out of power-on
   a_no_early_assign: assert property (
      @(posedge clk) disable iff (rst)
      !addrAssigned && !bootDone |=> !addrAssigned)
      else $error("assigned state entered without boot done");
   // A second-address marker keeps quiet on first-address traffic
   a_second_quiet: assert property (
      @(posedge clk) disable iff (rst)
      answersDPrime && !msgForDPrime |-> !msgAccept)
      else $error("second-address marker took other traffic");
   // Ra comes back when the supply is lost in the assigned state
   a_term_restored: assert property (
      @(posedge clk) disable iff (rst)
      addrAssigned && !supStable |=> termPresent)
      else $error("termination not restored on supply loss");

endmodule

/* File: tb/cmk_port_model.sv */
// Port controller model that powers the cable and sends messages
`timescale 1ns/1ns
module cmk_port_model (
   input wire logic clk,
   output logic supplyOk,
   output logic hardResetSeen,
   output logic cableResetSeen,
   output logic msgValid,
   output logic msgForPrime,
   output logic msgForDPrime
);
   // Supply off and lines quiet at power-up
   initial begin
      {supplyOk, hardResetSeen, cableResetSeen} = 3'h0;
      {msgValid, msgForPrime, msgForDPrime} = 3'h0;
   end
   // Supply switched just after a falling edge
   task automatic supply(input logic on);
      @(negedge clk);
      supplyOk = on;
   endtask
   // One-cycle message; released address lines invert, never hold
   task automatic send(input logic p, input logic d);
      @(negedge clk);
      {msgValid, msgForPrime, msgForDPrime} = {1'b1, p, d};
      @(negedge clk);
      {msgValid, msgForPrime, msgForDPrime} = {1'b0, ~p, ~d};
   endtask
   // Hard reset (0) or cable reset (1) for one cycle
   task automatic kick(input logic kind);
      @(negedge clk);
      {hardResetSeen, cableResetSeen} = {~kind, kind};
      @(negedge clk);
      {hardResetSeen, cableResetSeen} = 2'h0;
   endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench of the cable marker connection controller
`timescale 1ns/1ns
module testbench;
   // ==========================================
   // Signals and bookkeeping
   logic clk = 1'b0, rst = 1'b1, bootDone = 1'b0, addrStrap = 1'b1;
   logic supplyOk, hardResetSeen, cableResetSeen;
   logic msgValid, msgForPrime, msgForDPrime, msgAccept, termPresent;
   logic supplyDraw, addrAssigned, answersDPrime, stableFault;
   logic loneAccept, loneDPrime; // Outputs of the single-marker copy
   int error_cnt = 0;
   int checks_done = 0;
   logic expQ[$]; // Expected accept per message, oldest first
   logic loneQ[$]; // Expected accept of the single-marker copy
   logic [31:0] seed = 32'h4EA991BC;
   always #5 clk = ~clk;
   cmk_port_model partner (.clk(clk), .supplyOk(supplyOk),
      .hardResetSeen(hardResetSeen), .cableResetSeen(cableResetSeen),
      .msgValid(msgValid), .msgForPrime(msgForPrime),
      .msgForDPrime(msgForDPrime));
   // Short limit keeps the overrun case brief
   cmk_marker_fsm #(.STABLE_LIMIT_CYC(50), .MULTI_MARKER(1'b1)) DUT (
      .clk(clk), .rst(rst), .supplyOk(supplyOk), .bootDone(bootDone),
      .addrStrap(addrStrap), .hardResetSeen(hardResetSeen),
      .cableResetSeen(cableResetSeen), .msgValid(msgValid),
      .msgForPrime(msgForPrime), .msgForDPrime(msgForDPrime),
      .msgAccept(msgAccept), .termPresent(termPresent),
      .supplyDraw(supplyDraw), .addrAssigned(addrAssigned),
      .answersDPrime(answersDPrime), .stableFault(stableFault));
   // Single-marker copy on the same inputs: its strap must be ignored
   cmk_marker_fsm #(.STABLE_LIMIT_CYC(50), .MULTI_MARKER(1'b0)) lone (
      .clk(clk), .rst(rst), .supplyOk(supplyOk), .bootDone(bootDone),
      .addrStrap(addrStrap), .hardResetSeen(hardResetSeen),
      .cableResetSeen(cableResetSeen), .msgValid(msgValid),
      .msgForPrime(msgForPrime), .msgForDPrime(msgForDPrime),
      .msgAccept(loneAccept), .termPresent(), .supplyDraw(),
      .addrAssigned(), .answersDPrime(loneDPrime), .stableFault());
   // ==========================================
   // Helpers
   task automatic check(input logic seen, input logic exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %b want %b", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic msg(input logic p, input logic d, input logic exp,
      input logic loneExp);
      expQ.push_back(exp);
      loneQ.push_back(loneExp);
      partner.send(p, d);
   endtask
   // Supply on, then enough edges for the synchroniser
   task automatic power();
      partner.supply(1'b1);
      repeat (4) @(negedge clk);
   endtask
   task automatic boot();
      bootDone = 1'b1;
      @(negedge clk);
      bootDone = 0;
      @(negedge clk);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Accept is combinational, so it is read at the edge taking the message
   always @(posedge clk) begin
      if (msgValid === 1'b1 && expQ.size() > 0) begin
         check(msgAccept, expQ.pop_front());
         check(loneAccept, loneQ.pop_front());
      end
   end
   // Watchdog sized well above the whole sequence
   initial begin
      #20000;
      error_cnt++;
      conclude();
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check(termPresent, 1'b1);
      power();
      check(supplyDraw, 1'b1);
      msg(1'b0, 1'b1, 1'b0, 1'b0);
      check(termPresent, 1'b1);
      boot();
      check(addrAssigned, 1'b1);
      check(termPresent, 1'b0);
      check(stableFault, 1'b0);
      addrStrap = 1'b0; // Strap moves while powered: must be ignored
      for (int i = 0; i < 20; i++) begin
         seed = xs(seed);
         msg(seed[0], seed[1], seed[1], seed[0]);
      end
      check(answersDPrime, 1'b1);
      check(loneDPrime, 1'b0);
      $display("addressing test done");
      // Hard reset, cable reset, then supply loss
      for (int k = 0; k < 3; k++) begin
         if (k == 2) partner.supply(1'b0);
         else partner.kick(k[0]);
         repeat (4) @(negedge clk);
         check(addrAssigned, 1'b0);
         check(supplyDraw, k != 2);
         msg(1'b0, 1'b1, 1'b0, 1'b0);
         power();
         boot();
         check(addrAssigned, 1'b1);
      end
      $display("exit test done");
      partner.supply(1'b0);
      repeat (4) @(negedge clk);
      power();
      repeat (60) @(negedge clk);
      check(stableFault, 1'b1);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      check(answersDPrime, 1'b0);
      power();
      boot();
      msg(1'b1, 1'b0, 1'b1, 1'b1);
      msg(1'b0, 1'b1, 1'b0, 1'b0);
      $display("strap and fault test done");
      conclude();
   end
endmodule
